// *** common/dmarc_cfg.svh ***
/*
 * register map, field positions, reset values and codes of the
 * four-channel dma register block.
 * assumes: included by its bare name from the design file.
 */
`ifndef DMARC_CFG_SVH
`define DMARC_CFG_SVH

// per channel: eight word slots; channel n at n*CH_STRIDE
`define DMARC_CH_STRIDE    8'h08
`define DMARC_OFF_CTRL     3'h0
`define DMARC_OFF_TRIG     3'h1
`define DMARC_OFF_FBU      3'h2
`define DMARC_OFF_FBL      3'h3
`define DMARC_OFF_SBU      3'h4
`define DMARC_OFF_SBL      3'h5
`define DMARC_OFF_PAD      3'h6
`define DMARC_OFF_CNT      3'h7
// shared status block
`define DMARC_OFF_PWC      8'h20
`define DMARC_OFF_RQC      8'h21
`define DMARC_OFF_PPS      8'h22
`define DMARC_OFF_LCA      8'h23
`define DMARC_OFF_DSH      8'h24
`define DMARC_OFF_DSL      8'h25

// control word bits
`define DMARC_B_EN         15
`define DMARC_B_SIZE       14
`define DMARC_B_DIR        13
`define DMARC_B_HALF       12
`define DMARC_B_DUMMY_PERIPHERAL_WRITE      11
`define DMARC_CTRL_MASK    16'hF833
// trigger select; count and upper-byte masks
`define DMARC_B_FORCE      15
`define DMARC_TRIG_MASK    16'h00FF
`define DMARC_CAN_TX_CODE  8'h46
`define DMARC_CNT_MASK     16'h3FFF
`define DMARC_HI_MASK      16'h00FF

// mode codes
`define DMARC_AM_POSTINC   2'h0
`define DMARC_AM_NOINC     2'h1
`define DMARC_AM_PERIPH    2'h2
`define DMARC_LCA_NONE     4'hF

`endif

// *** common/dmarc_pkg.sv ***
/*
 * types shared by the dma register block.
 * assumes: dmarc_cfg.svh on the include path.
 */
package dmarc_pkg;
   typedef enum logic [1:0] {
      DMARC_IDLE = 2'h0,
      DMARC_READ = 2'h1,
      DMARC_WRIT = 2'h3
   } dmarc_state_e;

   // one bus request toward the sram port or the peripheral port
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        byte_sel;
      logic [23:0] addr;
   } dmarc_xfer_s;
endpackage

// *** logic/dmarc_top.sv ***
/*
 * four-channel dma register block with transfer sequencer.
 * assumes: one 250 mhz clock; a host on a plain strobe port; trigger
 * lines from same-clock peripheral logic; a sram port that takes one
 * request per cycle without stall; an external interrupt controller.
 */
// The implementer's own choices: the strobed register port and the register offsets.
// Notes on behaviour
// RULE1: four channels, each with full register set
// RULE2: transfer count is fourteen bits wide
// RULE3: shared status: collisions, last address, channel
// RULE4: each channel drives its own interrupt request
// RULE5: control bit 15 enables the channel
// RULE6: control bit 14 set means byte transfers
// RULE7: bit 13 set moves ram to peripheral
// RULE8: bit 12 set interrupts at half block
// RULE9: bit 11 adds null peripheral write
// RULE10: unimplemented bits ignore writes, read zero
// RULE11: bits 5-4 select addressing mode
// RULE12: bits 1-0 select continuous, one-shot, ping-pong
// RULE13: trigger bit 15 forces one transfer
// RULE14: force cleared only by hardware
// RULE15: trigger bits 7-0 pick the request source
// RULE16: can transmit code only with can present
// RULE17: 24-bit primary base split upper/lower
// RULE18: 24-bit secondary base split the same
// RULE19: block moves count plus one transfers
// RULE20: lowest channel number wins arbitration
// RULE21: ping-pong swaps base after each block
// RULE22: post-increment adds one or two, restarts
// RULE23: one-shot clears enable after final block
`timescale 1ns/10ps
`include "dmarc_cfg.svh"
module dmarc_top #(
   parameter int NCH     = 4,  // channel count
   parameter int NSRC    = 256, // trigger lines
   parameter bit HAS_CAN = 1'b1 // can transmit trigger present
) (
   input  wire logic          clock,       // system clock
   input  wire logic          rstn,        // async reset, low
   input  wire logic [7:0]    addr,        // register word address
   input  wire logic [15:0]   wdata,       // write data
   input  wire logic          wr,          // write strobe
   input  wire logic          rd,          // read strobe
   output logic      [15:0]   rdata_q,     // read data, next cycle
   input  wire logic [NSRC-1:0] trig,      // peripheral requests
   input  wire logic [15:0]   periph_addr, // peripheral indirect addr
   output dmarc_pkg::dmarc_xfer_s sram_q,  // sram request
   output dmarc_pkg::dmarc_xfer_s per_q,   // peripheral request
   output logic [15:0]        per_ptr_q,   // peripheral address
   output logic [NCH-1:0]     irq_q        // channel interrupt pulses
);
   // decode, grant width and status packing are sized for four channels
   if (NCH != 4) begin : g_bad_nch
      $error("dmarc_top serves four channels only");
   end
   if (NSRC != 256) begin : g_bad_nsrc
      $error("dmarc_top needs 256 trigger lines");
   end

   logic [15:0] ctrl_q [NCH];
   logic [7:0]  sel_q  [NCH];
   logic [NCH-1:0] force_q;
   logic [23:0] fb_q   [NCH];
   logic [23:0] sb_q   [NCH];
   logic [15:0] pad_q  [NCH];
   logic [13:0] cnt_q  [NCH];
   logic [13:0] done_q [NCH];   // transfers done in block
   logic [23:0] cur_q  [NCH];   // running sram address
   logic [NCH-1:0] pp_q;        // 1: secondary buffer active
   logic [NCH-1:0] pend_q;
   logic [NCH-1:0] pwc_q, rqc_q;
   logic [3:0]  lca_q;
   logic [23:0] dsadr_q;
   dmarc_pkg::dmarc_state_e st_q;
   logic [1:0]  act_q;
   logic        trig_q [NCH];

   // channel slot hit for a bus address
   function automatic logic ch_hit(input logic [7:0] a, input int c,
                                   input logic [2:0] off);
      ch_hit = (a == 8'(c * `DMARC_CH_STRIDE + off));
   endfunction

   // a selectable trigger code; can tx only when present
   function automatic logic code_ok(input logic [7:0] c);
      code_ok = HAS_CAN || (c != `DMARC_CAN_TX_CODE); // see RULE16
   endfunction

   // grant: fixed priority, channel 0 first
   logic [1:0] gnt;
   logic       any;
   always_comb begin
      gnt = 2'h0;
      any = 1'b0;
      for (int c = NCH - 1; c >= 0; c--) begin
         if (pend_q[c]) begin
            gnt = 2'(c);
            any = 1'b1;  // see RULE20
         end
      end
   end

   // the granted transfer finishes on the write beat
   logic fin;
   assign fin = (st_q == dmarc_pkg::DMARC_WRIT);

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gch
         logic en, last, halfp, oneshot, pingp;
         assign en      = ctrl_q[g][`DMARC_B_EN];
         assign last    = fin && act_q == 2'(g) && done_q[g] == cnt_q[g];
         assign halfp   = fin && act_q == 2'(g) &&
                          done_q[g] == (cnt_q[g] >> 1);
         assign oneshot = ctrl_q[g][0]; // see RULE12
         assign pingp   = ctrl_q[g][1];

         // control register; enable dropped after one-shot end
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               ctrl_q[g] <= 16'h0000;
            end else if (wr && ch_hit(addr, g, `DMARC_OFF_CTRL)) begin
               ctrl_q[g] <= wdata & `DMARC_CTRL_MASK; // see RULE10
            end else if (last && oneshot && (!pingp || pp_q[g])) begin
               ctrl_q[g][`DMARC_B_EN] <= 1'b0; // see RULE23
            end
         end

         // trigger select; force is set-only by software
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               sel_q[g]   <= 8'h00;
               force_q[g] <= 1'b0;
            end else begin
               if (wr && ch_hit(addr, g, `DMARC_OFF_TRIG) &&
                   code_ok(wdata[7:0]))
                  sel_q[g] <= wdata[7:0]; // see RULE15
               if (!en)
                  force_q[g] <= 1'b0;  // see RULE14
               else if (wr && ch_hit(addr, g, `DMARC_OFF_TRIG) &&
                        wdata[`DMARC_B_FORCE])
                  force_q[g] <= 1'b1;  // see RULE13
               else if (fin && act_q == 2'(g))
                  force_q[g] <= 1'b0;  // see RULE14
            end
         end

         // base, peripheral pointer and count registers
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               fb_q[g]  <= 24'h000000;
               sb_q[g]  <= 24'h000000;
               pad_q[g] <= 16'h0000;
               cnt_q[g] <= 14'h0000;
            end else if (wr) begin
               if (ch_hit(addr, g, `DMARC_OFF_FBU))
                  fb_q[g][23:16] <= wdata[7:0]; // see RULE17
               if (ch_hit(addr, g, `DMARC_OFF_FBL))
                  fb_q[g][15:0] <= wdata;       // see RULE17
               if (ch_hit(addr, g, `DMARC_OFF_SBU))
                  sb_q[g][23:16] <= wdata[7:0]; // see RULE18
               if (ch_hit(addr, g, `DMARC_OFF_SBL))
                  sb_q[g][15:0] <= wdata;       // see RULE18
               if (ch_hit(addr, g, `DMARC_OFF_PAD))
                  pad_q[g] <= wdata;
               if (ch_hit(addr, g, `DMARC_OFF_CNT))
                  cnt_q[g] <= wdata[13:0];      // see RULE2
            end
         end

         // request pending: peripheral edge or force; collision flag
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               trig_q[g] <= 1'b0;
               pend_q[g] <= 1'b0;
               rqc_q[g]  <= 1'b0;
            end else begin
               trig_q[g] <= trig[sel_q[g]];
               if (!en)
                  pend_q[g] <= 1'b0;     // see RULE5
               // force pends only when not queued or in flight, else the
               // still-set force bit would queue a second transfer
               else if ((trig[sel_q[g]] && !trig_q[g]) ||
                        (force_q[g] && !pend_q[g] &&
                         !(st_q != dmarc_pkg::DMARC_IDLE &&
                           act_q == 2'(g))))
                  pend_q[g] <= 1'b1;     // see RULE13
               else if (any && st_q == dmarc_pkg::DMARC_IDLE &&
                        gnt == 2'(g))
                  pend_q[g] <= 1'b0;
               if (en && force_q[g] && trig[sel_q[g]] && !trig_q[g])
                  rqc_q[g] <= 1'b1;      // see RULE3
            end
         end

         // block progress, address walk and ping-pong buffer
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               done_q[g] <= 14'h0000;
               cur_q[g]  <= 24'h000000;
               pp_q[g]   <= 1'b0;
            end else if (!en) begin
               done_q[g] <= 14'h0000;
               cur_q[g]  <= pp_q[g] ? sb_q[g] : fb_q[g];
            end else if (fin && act_q == 2'(g)) begin
               if (last) begin
                  done_q[g] <= 14'h0000;  // see RULE19
                  pp_q[g]   <= pingp ? !pp_q[g] : pp_q[g]; // see RULE21
                  cur_q[g]  <= (pingp && !pp_q[g]) ? sb_q[g] :
                               (pingp ? fb_q[g] :
                                (pp_q[g] ? sb_q[g] : fb_q[g]));
               end else begin
                  done_q[g] <= done_q[g] + 14'h0001;
                  if (ctrl_q[g][5:4] == `DMARC_AM_POSTINC)
                     cur_q[g] <= cur_q[g] + (ctrl_q[g][`DMARC_B_SIZE] ?
                                 24'h000001 : 24'h000002); // see RULE22
               end
            end
         end

         // interrupt pulse at half or full block
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn)
               irq_q[g] <= 1'b0;
            else
               irq_q[g] <= ctrl_q[g][`DMARC_B_HALF] ? halfp : last;
         end                                         // see RULE4 RULE8
      end
   endgenerate

   // sequencer: read beat then write beat for the granted channel
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         st_q  <= dmarc_pkg::DMARC_IDLE;
         act_q <= 2'h0;
      end else begin
         case (st_q)
            dmarc_pkg::DMARC_IDLE: if (any) begin
               st_q  <= dmarc_pkg::DMARC_READ;
               act_q <= gnt;
            end
            dmarc_pkg::DMARC_READ: st_q <= dmarc_pkg::DMARC_WRIT;
            dmarc_pkg::DMARC_WRIT: st_q <= dmarc_pkg::DMARC_IDLE;
            default: st_q <= dmarc_pkg::DMARC_IDLE;
         endcase
      end
   end

   // bus requests; direction picks which side reads first
   logic [15:0] c_ctl;
   logic [23:0] ram_a;
   assign c_ctl = ctrl_q[act_q];
   assign ram_a = cur_q[act_q];
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sram_q    <= '0;
         per_q     <= '0;
         per_ptr_q <= 16'h0000;
      end else begin
         sram_q <= '0;
         per_q  <= '0;
         per_ptr_q <= (c_ctl[5:4] == `DMARC_AM_PERIPH) ? periph_addr :
                      pad_q[act_q];               // see RULE11
         if (st_q != dmarc_pkg::DMARC_IDLE) begin
            // see RULE7: ram side reads on read beat when bit set
            sram_q.valid <= c_ctl[`DMARC_B_DIR] ==
                            (st_q == dmarc_pkg::DMARC_READ);
            sram_q.write <= st_q == dmarc_pkg::DMARC_WRIT;
            sram_q.byte_sel <= c_ctl[`DMARC_B_SIZE];   // see RULE6
            sram_q.addr  <= (c_ctl[5:4] == `DMARC_AM_PERIPH) ?
                            {8'h00, periph_addr} : ram_a;
            per_q.valid  <= (c_ctl[`DMARC_B_DIR] !=
                            (st_q == dmarc_pkg::DMARC_READ)) ||
                            (fin && c_ctl[`DMARC_B_DUMMY_PERIPHERAL_WRITE] &&
                             !c_ctl[`DMARC_B_DIR]);   // see RULE9
            per_q.write  <= st_q == dmarc_pkg::DMARC_WRIT;
            per_q.byte_sel <= c_ctl[`DMARC_B_SIZE];
            per_q.addr   <= 24'(pad_q[act_q]);
         end
      end
   end

   // shared status: last channel, last sram address, write collision
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lca_q   <= `DMARC_LCA_NONE;
         dsadr_q <= 24'h000000;
         pwc_q   <= '0;
      end else begin
         if (fin) begin
            lca_q   <= {2'h0, act_q};   // see RULE3
            dsadr_q <= ram_a;
         end
         // a new peripheral write while the previous is not finished
         if (fin && c_ctl[`DMARC_B_DIR] && pend_q[act_q] &&
             !force_q[act_q])
            pwc_q[act_q] <= 1'b1;
      end
   end

   // register read mux, data in the cycle after the strobe
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= 16'h0000;  // unmapped and idle read zero
         if (rd) begin
            for (int c = 0; c < NCH; c++) begin    // see RULE1
               if (ch_hit(addr, c, `DMARC_OFF_CTRL)) rdata_q <= ctrl_q[c];
               if (ch_hit(addr, c, `DMARC_OFF_TRIG))
                  rdata_q <= {force_q[c], 7'h00, sel_q[c]};
               if (ch_hit(addr, c, `DMARC_OFF_FBU))
                  rdata_q <= {8'h00, fb_q[c][23:16]}; // see RULE10
               if (ch_hit(addr, c, `DMARC_OFF_FBL)) rdata_q <= fb_q[c][15:0];
               if (ch_hit(addr, c, `DMARC_OFF_SBU))
                  rdata_q <= {8'h00, sb_q[c][23:16]};
               if (ch_hit(addr, c, `DMARC_OFF_SBL)) rdata_q <= sb_q[c][15:0];
               if (ch_hit(addr, c, `DMARC_OFF_PAD)) rdata_q <= pad_q[c];
               if (ch_hit(addr, c, `DMARC_OFF_CNT))
                  rdata_q <= {2'h0, cnt_q[c]};
            end
            case (addr)
               `DMARC_OFF_PWC: rdata_q <= {12'h000, pwc_q};
               `DMARC_OFF_RQC: rdata_q <= {12'h000, rqc_q};
               `DMARC_OFF_PPS: rdata_q <= {12'h000, pp_q};
               `DMARC_OFF_LCA: rdata_q <= {12'h000, lca_q};
               `DMARC_OFF_DSH: rdata_q <= {8'h00, dsadr_q[23:16]};
               `DMARC_OFF_DSL: rdata_q <= dsadr_q[15:0];
               default: ;
            endcase
         end
      end
   end

   // checks
   chk_force_sw_clear: assert property (@(posedge clock) disable iff (!rstn)
      ($fell(force_q[1]) |-> !$past(ctrl_q[1][`DMARC_B_EN]) ||
       $past(fin && act_q == 2'h1)))
      else $error("force cleared without completion"); // see RULE14
   chk_idle_when_off: assert property (@(posedge clock) disable iff (!rstn)
      (!ctrl_q[0][`DMARC_B_EN] |=> !pend_q[0]))
      else $error("disabled channel pending"); // see RULE5
   chk_prio_grant: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == dmarc_pkg::DMARC_IDLE && pend_q[0] |=> act_q == 2'h0))
      else $error("channel 0 not granted first"); // see RULE20
   chk_reserved_zero: assert property (@(posedge clock) disable iff (!rstn)
      ((ctrl_q[1] & ~`DMARC_CTRL_MASK) == 16'h0000))
      else $error("reserved control bits set"); // see RULE10
   chk_seq_length: assert property (@(posedge clock) disable iff (!rstn)
      (st_q == dmarc_pkg::DMARC_READ |=> st_q == dmarc_pkg::DMARC_WRIT
       ##1 st_q == dmarc_pkg::DMARC_IDLE))
      else $error("transfer not two beats"); // see RULE19
   chk_byte_step: assert property (@(posedge clock) disable iff (!rstn)
      (fin && act_q == 2'h0 && ctrl_q[0][5:4] == `DMARC_AM_POSTINC &&
       done_q[0] != cnt_q[0] && ctrl_q[0][`DMARC_B_EN] |=>
       cur_q[0] == $past(cur_q[0]) + ($past(ctrl_q[0][`DMARC_B_SIZE]) ?
                   24'h000001 : 24'h000002)))
      else $error("address step wrong"); // see RULE22
   chk_oneshot_off: assert property (@(posedge clock) disable iff (!rstn)
      (gch[0].last && ctrl_q[0][1:0] == 2'h1 && !(wr &&
       ch_hit(addr, 0, `DMARC_OFF_CTRL)) |=> !ctrl_q[0][`DMARC_B_EN]))
      else $error("one-shot stayed enabled"); // see RULE23
   chk_pp_swap: assert property (@(posedge clock) disable iff (!rstn)
      (gch[1].last && ctrl_q[1][1] && ctrl_q[1][`DMARC_B_EN]
       |=> pp_q[1] != $past(pp_q[1])))
      else $error("ping-pong did not swap"); // see RULE21
   cov_force: cover property (@(posedge clock) $rose(force_q[1]));
   cov_block: cover property (@(posedge clock) gch[0].last);
   cov_contend: cover property (@(posedge clock) pend_q[0] && pend_q[1]);
endmodule

// *** verification/dmarc_periph_model.sv ***
/*
 * peripheral side model: request lines and a peripheral address source.
 * assumes: same clock as the dma block; the bench asks for one request
 * at a time through fire_stb and fire_code.
 */
`timescale 1ns/10ps
module dmarc_periph_model (
   input  wire logic         clock,       // system clock
   input  wire logic         rstn,        // async reset, low
   input  wire logic [7:0]   fire_code,   // request line to raise
   input  wire logic         fire_stb,    // raise it next cycle
   output logic      [255:0] trig,        // request lines
   output logic      [15:0]  periph_addr  // peripheral address
);
   // one-cycle request; the low cycle after it gives a fresh rising edge
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         trig <= '0;
      end else begin
         trig <= '0;
         if (fire_stb) begin
            trig[fire_code] <= 1'b1;
         end
      end
   end

   // unused address keeps moving so a stale value is never mistaken
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         periph_addr <= 16'h0ABC;
      end else begin
         periph_addr <= ~periph_addr;
      end
   end
endmodule

// *** verification/dmarc_top_test.sv ***
/*
 * self-checking bench for the dma register block.
 * assumes: assertions live in the design; the peripheral model drives
 * the request lines; sram and peripheral ports never stall.
 */
`timescale 1ns/10ps
module dmarc_top_test;
   logic         clock;        // system clock
   logic         rstn;         // async reset, low
   logic [7:0]   addr;         // register address
   logic [15:0]  wdata;        // write data
   logic         wr;           // write strobe
   logic         rd;           // read strobe
   logic [15:0]  rdata_q;      // read data
   logic [255:0] trig;         // request lines
   logic [15:0]  periph_addr;  // peripheral address
   logic [15:0]  per_ptr_q;    // pointer out
   logic [3:0]   irq_q;        // interrupts
   logic [7:0]   fire_code;    // model request line
   logic         fire_stb;     // model request strobe
   logic [15:0]  rv;           // read value
   int           num_errors;   // mismatches
   int           checks_done;  // comparisons
   int           irq_cnt[4];   // pulses per channel
   int           half_at;      // beats seen at channel 2 irq
   int           nul_wr;       // peripheral writes seen
   dmarc_pkg::dmarc_xfer_s sram_q;   // sram request
   dmarc_pkg::dmarc_xfer_s per_q;    // peripheral request
   dmarc_pkg::dmarc_xfer_s slog[$];  // sram beats seen
   logic [15:0]  pexp[$];      // peripheral address behind each beat

   // register rows: address, written value, value read back
   localparam logic [7:0] RA[12] = '{8'h00, 8'h09, 8'h11, 8'h12, 8'h13,
      8'h1C, 8'h1D, 8'h0F, 8'h1E, 8'h20, 8'h23, 8'h30};
   localparam logic [15:0] RW[12] = '{16'h7FFF, 16'h7FFF, 16'h0046,
      16'hFFFF, 16'hFFFF, 16'hABCD, 16'h1234, 16'hFFFF, 16'hBEEF,
      16'hFFFF, 16'h0000, 16'hFFFF};
   localparam logic [15:0] RE[12] = '{16'h7833, 16'h00FF, 16'h0046,
      16'h00FF, 16'hFFFF, 16'h00CD, 16'h1234, 16'h3FFF, 16'hBEEF,
      16'h0000, 16'h000F, 16'h0000};

   dmarc_top #(.NCH(4), .NSRC(256), .HAS_CAN(1'b1)) i_dmarc_top (
      .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata_q(rdata_q), .trig(trig), .periph_addr(periph_addr),
      .sram_q(sram_q), .per_q(per_q), .per_ptr_q(per_ptr_q),
      .irq_q(irq_q));

   dmarc_periph_model i_dmarc_periph_model (
      .clock(clock), .rstn(rstn), .fire_code(fire_code),
      .fire_stb(fire_stb), .trig(trig), .periph_addr(periph_addr));

   // clock of 4 ns
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // beat and interrupt log, sampled where outputs have settled
   always @(posedge clock) begin
      if (rstn === 1'b1) begin
         if (sram_q.valid === 1'b1) begin
            slog.push_back(sram_q);
            pexp.push_back(~periph_addr); // model flips it every edge
         end
         if (per_q.valid === 1'b1 && per_q.write === 1'b1) nul_wr++;
         for (int c = 0; c < 4; c++)
            if (irq_q[c] === 1'b1) irq_cnt[c]++;
         if (irq_q[2] === 1'b1) half_at = slog.size();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata_q;
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
   endtask

   task automatic clear_log();
      slog.delete();
      pexp.delete();
      irq_cnt = '{0, 0, 0, 0};
      nul_wr = 0;
      half_at = -1;
   endtask

   // bounded wait for beats, then room for completion bookkeeping
   task automatic wait_beats(input int n);
      for (int k = 0; k < 60 && slog.size() < n; k++) @(posedge clock);
      repeat (4) @(posedge clock);
   endtask

   task automatic fire(input logic [7:0] c, input int n);
      @(posedge clock);
      fire_code <= c;
      fire_stb <= 1'b1;
      @(posedge clock);
      fire_stb <= 1'b0;
      wait_beats(n);
   endtask

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // watchdog well past the few hundred cycles the tests need
   initial begin
      #60000;
      num_errors++;
      complete_run();
   end

   initial begin
      rstn = 1'b0; addr = 8'h00; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
      fire_code = 8'h00; fire_stb = 1'b0;
      num_errors = 0; checks_done = 0;
      clear_log();
      do_reset();
      for (int i = 0; i < 12; i++) begin
         wr_reg(RA[i], RW[i]);
         rd_reg(RA[i], rv);
         check(rv, RE[i]);
      end
      $display("register rows done");
      // second reset clears what the rows left behind
      do_reset();
      rd_reg(8'h00, rv); check(rv, 16'h0000);
      rd_reg(8'h0F, rv); check(rv, 16'h0000);
      rd_reg(8'h23, rv); check(rv, 16'h000F);
      $display("reset values done");
      // ch0: word, peripheral to ram, post-increment, one-shot
      wr_reg(8'h03, 16'h1000); wr_reg(8'h07, 16'h0003);
      wr_reg(8'h01, 16'h000D); wr_reg(8'h00, 16'h8001);
      clear_log();
      for (int i = 0; i < 4; i++) fire(8'h0D, i + 1);
      check(slog.size(), 4);
      foreach (slog[i]) begin
         check(slog[i].addr, 24'h001000 + 2 * i);
         check({slog[i].write, slog[i].byte_sel}, 2'b10);
      end
      check(irq_cnt[0], 1);
      rd_reg(8'h00, rv); check(rv, 16'h0001);
      rd_reg(8'h23, rv); check(rv, 16'h0000);
      fire(8'h0D, 5);
      check(slog.size(), 4);
      $display("one-shot block done");
      // ch1: byte, ram to peripheral, no increment, continuous ping-pong
      wr_reg(8'h0B, 16'h2000); wr_reg(8'h0D, 16'h3000);
      wr_reg(8'h0F, 16'h0001); wr_reg(8'h09, 16'h00FF);
      wr_reg(8'h08, 16'hE012);
      clear_log();
      for (int i = 0; i < 4; i++) begin
         wr_reg(8'h09, 16'h80FF);
         wait_beats(i + 1);
      end
      check(slog.size(), 4);
      foreach (slog[i]) begin
         check(slog[i].addr, (i < 2) ? 24'h002000 : 24'h003000);
         check({slog[i].write, slog[i].byte_sel}, 2'b01);
      end
      rd_reg(8'h09, rv); check(rv, 16'h00FF);
      rd_reg(8'h08, rv); check(rv, 16'hE012);
      check(irq_cnt[1], 2);
      wr_reg(8'h08, 16'h0000);
      $display("force ping-pong done");
      // ch2: half-block interrupt
      wr_reg(8'h13, 16'h0100); wr_reg(8'h17, 16'h0003);
      wr_reg(8'h11, 16'h000D); wr_reg(8'h10, 16'h9001);
      clear_log();
      for (int i = 0; i < 4; i++) fire(8'h0D, i + 1);
      check(irq_cnt[2], 1);
      check(half_at, 2);
      $display("half interrupt done");
      // ch2: peripheral indirect, one-shot ping-pong over two blocks
      wr_reg(8'h17, 16'h0000);
      wr_reg(8'h10, 16'h8023);
      clear_log();
      fire(8'h0D, 1);
      rd_reg(8'h10, rv); check(rv, 16'h8023);
      rd_reg(8'h22, rv); check(rv, 16'h0004);
      fire(8'h0D, 2);
      rd_reg(8'h10, rv); check(rv, 16'h0023);
      check(slog.size(), 2);
      foreach (slog[i]) check(slog[i].addr, {8'h00, pexp[i]});
      $display("peripheral indirect done");
      // ch0 and ch3 on one request: lower channel first; ch3 null write
      wr_reg(8'h03, 16'h5000); wr_reg(8'h07, 16'h0000);
      wr_reg(8'h01, 16'h000E); wr_reg(8'h00, 16'h8001);
      wr_reg(8'h1B, 16'h4000); wr_reg(8'h1F, 16'h0000);
      wr_reg(8'h1E, 16'h0BEE);
      wr_reg(8'h19, 16'h000E); wr_reg(8'h18, 16'h8801);
      clear_log();
      fire(8'h0E, 2);
      check(slog.size(), 2);
      check(slog[0].addr, 24'h005000);
      check(slog[1].addr, 24'h004000);
      check(nul_wr, 1);
      rd_reg(8'h23, rv); check(rv, 16'h0003);
      check(per_ptr_q, 16'h0BEE);
      $display("priority and null write done");
      complete_run();
   end
endmodule
